/* verilog/dbgtp_top.sv */
// Debug-event lines and emulation trace pins for the dual-core device
//
// Overview of operation
// - Select high moves both event lines to the alternate pins.
// - Outside pull of controller line requests debug; same line acks.
// - Controller debug entry pulls its line for exactly three clocks.
// - Outside pull of sigproc line requests its debug; same line acks.
// - Sigproc debug entry pulls its event line for three clocks.
// - Trace pins reset to general-purpose inputs until set for trace.
// - Size pins show controller access size in trace use, else GPIO.
// - State pins show controller pipeline state in trace use, else GPIO.
module dbgtp_top
	import dbgtp_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// Location select pin
	input  wire logic                  debug_pin_location_select,
	// Controller debug-event pins, primary and alternate
	input  wire logic                  controller_debug_event_in,
	output logic                       controller_debug_event_out,
	output logic                       controller_debug_event_oe,
	input  wire logic                  controller_debug_event_alt_in,
	output logic                       controller_debug_event_alt_out,
	output logic                       controller_debug_event_alt_oe,
	// Signal-processor debug-event pins, primary and alternate
	input  wire logic                  sigproc_debug_event_in,
	output logic                       sigproc_debug_event_out,
	output logic                       sigproc_debug_event_oe,
	input  wire logic                  sigproc_debug_event_alt_in,
	output logic                       sigproc_debug_event_alt_out,
	output logic                       sigproc_debug_event_alt_oe,
	// Core debug handshakes
	input  wire logic                  controller_debug_entered,
	output logic                       controller_debug_request,
	input  wire logic                  sigproc_debug_entered,
	output logic                       sigproc_debug_request,
	// Controller trace source
	input  wire dbgtp_trace_s          trace_source,
	// Trace mode programming
	input  wire logic                  trace_mode_write,
	input  wire logic [TRACE_PINS-1:0] trace_mode_value,
	output logic [TRACE_PINS-1:0]      trace_mode,
	// General-purpose side of the trace pins
	input  wire logic [TRACE_PINS-1:0] gpio_out_value,
	input  wire logic [TRACE_PINS-1:0] gpio_out_enable,
	output logic [TRACE_PINS-1:0]      gpio_in_level,
	// Trace pins
	input  wire logic [TRACE_PINS-1:0] trace_pin_in,
	output logic [TRACE_PINS-1:0]      trace_pin_out,
	output logic [TRACE_PINS-1:0]      trace_pin_oe
);

	logic [SYNC_DEPTH-1:0]                 sel_sync;
	logic                                  alt_sel;
	logic [TRACE_PINS-1:0][SYNC_DEPTH-1:0] pin_sync;
	logic [TRACE_PINS-1:0]                 trace_bits;
	dbgtp_pin_s                            ctl_prim;
	dbgtp_pin_s                            ctl_alt;
	dbgtp_pin_s                            sp_prim;
	dbgtp_pin_s                            sp_alt;

	// Select pin filtered like any other pin input
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sel_sync <= '0;
			alt_sel <= 1'b0;
		end
		else
		begin
			sel_sync <= {sel_sync[SYNC_DEPTH-2:0], debug_pin_location_select};
			if (sel_sync[1] == sel_sync[2])
				alt_sel <= sel_sync[2];
		end
	end

	dbgtp_event_line u_controller_event (
		.clk           (clk),
		.rst_n         (rst_n),
		.alt_sel       (alt_sel),
		.prim_in       (controller_debug_event_in),
		.alt_in        (controller_debug_event_alt_in),
		.core_entered  (controller_debug_entered),
		.debug_request (controller_debug_request),
		.prim_pin      (ctl_prim),
		.alt_pin       (ctl_alt)
	);

	dbgtp_event_line u_sigproc_event (
		.clk           (clk),
		.rst_n         (rst_n),
		.alt_sel       (alt_sel),
		.prim_in       (sigproc_debug_event_in),
		.alt_in        (sigproc_debug_event_alt_in),
		.core_entered  (sigproc_debug_entered),
		.debug_request (sigproc_debug_request),
		.prim_pin      (sp_prim),
		.alt_pin       (sp_alt)
	);

	// Event pin drive is already registered inside the line handlers
	assign controller_debug_event_out = ctl_prim.out;
	assign controller_debug_event_oe = ctl_prim.oe;
	assign controller_debug_event_alt_out = ctl_alt.out;
	assign controller_debug_event_alt_oe = ctl_alt.oe;
	assign sigproc_debug_event_out = sp_prim.out;
	assign sigproc_debug_event_oe = sp_prim.oe;
	assign sigproc_debug_event_alt_out = sp_alt.out;
	assign sigproc_debug_event_alt_oe = sp_alt.oe;

	// Trace mode, cleared at reset so all pins start as inputs
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			trace_mode <= TRACE_MODE_RESET;
		else if (trace_mode_write)
			trace_mode <= trace_mode_value;
	end

	assign trace_bits = {trace_source.pipeline_state_code,
		trace_source.access_size_code};

	// Pin mux, output and enable registered per pin so the pads see no glitches
	for (genvar p = 0; p < TRACE_PINS; p++)
	begin : g_pin
		always_ff @(posedge clk)
		begin
			if (!rst_n)
			begin
				trace_pin_out[p] <= 1'b0;
				trace_pin_oe[p] <= 1'b0;
			end
			else if (trace_mode[p])
			begin
				trace_pin_out[p] <= trace_bits[p];
				trace_pin_oe[p] <= 1'b1;
			end
			else
			begin
				trace_pin_out[p] <= gpio_out_value[p];
				trace_pin_oe[p] <= gpio_out_enable[p];
			end
		end

		always_ff @(posedge clk)
		begin
			if (!rst_n)
			begin
				pin_sync[p] <= '0;
				gpio_in_level[p] <= 1'b0;
			end
			else
			begin
				pin_sync[p] <= {pin_sync[p][SYNC_DEPTH-2:0], trace_pin_in[p]};
				if (pin_sync[p][1] == pin_sync[p][2])
					gpio_in_level[p] <= pin_sync[p][2];
			end
		end
	end

	chk_reset_all_inputs: assert property (@(posedge clk)
		!rst_n |=> (trace_pin_oe == '0) && (trace_mode == TRACE_MODE_RESET))
		else $error("trace pins not inputs after reset");

	chk_trace_size_code: assert property (@(posedge clk) disable iff (!rst_n)
		trace_mode[SIZE_LSB] |=> trace_pin_oe[SIZE_LSB]
			&& trace_pin_out[SIZE_LSB]
			== $past(trace_source.access_size_code[0]))
		else $error("size code not on pin");

	chk_trace_pstat_code: assert property (@(posedge clk) disable iff (!rst_n)
		trace_mode[PSTAT_LSB] |=> trace_pin_oe[PSTAT_LSB]
			&& trace_pin_out[PSTAT_LSB]
			== $past(trace_source.pipeline_state_code[0]))
		else $error("pipeline state not on pin");

	chk_gpio_follows: assert property (@(posedge clk) disable iff (!rst_n)
		!trace_mode[PSTAT_LSB] |=> trace_pin_oe[PSTAT_LSB]
			== $past(gpio_out_enable[PSTAT_LSB]))
		else $error("gpio enable not passed");

	chk_alt_releases_prim: assert property (@(posedge clk) disable iff (!rst_n)
		alt_sel ##1 alt_sel |-> !controller_debug_event_oe
			&& !sigproc_debug_event_oe)
		else $error("primary line driven while moved");

	chk_ctl_ack_length: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(controller_debug_event_oe) ##1 !alt_sel [*3]
			|-> $past(controller_debug_event_oe)
			&& $past(controller_debug_event_oe, 2)
			&& !controller_debug_event_oe)
		else $error("controller ack length wrong");

	chk_ctl_ack_follows: assert property (@(posedge clk) disable iff (!rst_n)
		controller_debug_entered && !alt_sel ##1 !alt_sel
			|-> ##[0:8] controller_debug_event_oe)
		else $error("controller entry not acknowledged");

	chk_sp_ack_follows: assert property (@(posedge clk) disable iff (!rst_n)
		sigproc_debug_entered && alt_sel ##1 alt_sel
			|-> ##[0:8] sigproc_debug_event_alt_oe)
		else $error("sigproc entry not acknowledged");

	chk_request_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		controller_debug_request |=> !controller_debug_request)
		else $error("request longer than one cycle");

endmodule : dbgtp_top

/* verilog/dbgtp_pkg.sv */
// Shared constants and carrier types for the debug event and trace pins
package dbgtp_pkg;

	localparam int unsigned ACK_CYCLES = 3;
	localparam int unsigned SETTLE_CYCLES = 4;
	localparam int unsigned CNT_W = 3;
	localparam int unsigned SYNC_DEPTH = 3;
	localparam int unsigned SIZE_W = 2;
	localparam int unsigned PSTAT_W = 4;
	localparam int unsigned TRACE_PINS = SIZE_W + PSTAT_W;
	localparam int unsigned SIZE_LSB = 0;
	localparam int unsigned PSTAT_LSB = SIZE_W;
	localparam logic [TRACE_PINS-1:0] TRACE_MODE_RESET = 6'h00;
	localparam logic PIN_LOW = 1'b0;

	localparam logic [CNT_W-1:0] ACK_LAST = CNT_W'(ACK_CYCLES - 1);
	localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;

	typedef enum logic [2:0] {
		EV_IDLE = 3'b001,
		EV_ACK  = 3'b010,
		EV_HOLD = 3'b100
	} dbgtp_ev_state_e;

	// Controller trace content presented on the emulation pins
	typedef struct packed {
		logic [PSTAT_W-1:0] pipeline_state_code;
		logic [SIZE_W-1:0]  access_size_code;
	} dbgtp_trace_s;

	// One open-drain pin as seen from the device
	typedef struct packed {
		logic out;
		logic oe;
	} dbgtp_pin_s;

endpackage : dbgtp_pkg

/* verilog/dbgtp_event_line.sv */
// Debug-event line handler for one core, primary and alternate location
module dbgtp_event_line
	import dbgtp_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Location select, already synchronised
	input  wire logic alt_sel,
	// Raw pin levels
	input  wire logic prim_in,
	input  wire logic alt_in,
	// Core side
	input  wire logic core_entered,
	output logic      debug_request,
	// Pin drive
	output dbgtp_pin_s prim_pin,
	output dbgtp_pin_s alt_pin
);

	logic [1:0][SYNC_DEPTH-1:0] sync;
	logic [1:0]                 level;
	logic                       line_now;
	logic                       line_prev;
	logic [CNT_W-1:0]           cnt;
	logic                       pulling;
	dbgtp_ev_state_e            state;

	// Three-stage synchroniser, level taken once stages two and three agree
	for (genvar i = 0; i < 2; i++)
	begin : g_sync
		always_ff @(posedge clk)
		begin
			if (!rst_n)
			begin
				sync[i] <= '1;
				level[i] <= 1'b1;
			end
			else
			begin
				sync[i] <= {sync[i][SYNC_DEPTH-2:0], (i == 0) ? prim_in : alt_in};
				if (sync[i][1] == sync[i][2])
					level[i] <= sync[i][2];
			end
		end
	end

	assign line_now = alt_sel ? level[1] : level[0];

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			line_prev <= 1'b1;
		else
			line_prev <= line_now;
	end

	// Own pull reads back late, so HOLD waits out the synchroniser first
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state <= EV_IDLE;
			cnt <= CNT_ZERO;
		end
		else
		begin
			unique case (state)
				EV_IDLE:
				begin
					if (core_entered)
					begin
						state <= EV_ACK;
						cnt <= ACK_LAST;
					end
				end
				EV_ACK:
				begin
					if (cnt == CNT_ZERO)
					begin
						state <= EV_HOLD;
						cnt <= SETTLE_LAST;
					end
					else
						cnt <= cnt - 1'b1;
				end
				EV_HOLD:
				begin
					if (cnt != CNT_ZERO)
						cnt <= cnt - 1'b1;
					else if (line_now)
						state <= EV_IDLE;
				end
				default:
				begin
					state <= EV_IDLE;
					cnt <= CNT_ZERO;
				end
			endcase
		end
	end

	assign pulling = (state == EV_ACK);

	// Falling edge of the shared line is an external request
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			debug_request <= 1'b0;
		else
			debug_request <= (state == EV_IDLE) && !core_entered
				&& line_prev && !line_now;
	end

	// Only ever pull low; the unselected location stays released
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			prim_pin <= '{out: PIN_LOW, oe: 1'b0};
			alt_pin <= '{out: PIN_LOW, oe: 1'b0};
		end
		else
		begin
			prim_pin <= '{out: PIN_LOW, oe: pulling && !alt_sel};
			alt_pin <= '{out: PIN_LOW, oe: pulling && alt_sel};
		end
	end

	chk_ack_three_cycles: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(state == EV_ACK) |=> (state == EV_ACK) [*2] ##1 (state == EV_HOLD))
		else $error("ack phase not three cycles");

	chk_pin_drives_low: assert property (@(posedge clk) disable iff (!rst_n)
		!prim_pin.out && !alt_pin.out
			&& ((prim_pin.oe || alt_pin.oe)
			== ($past(pulling) && $past(rst_n))))
		else $error("event pin drive wrong");

	chk_one_location: assert property (@(posedge clk) disable iff (!rst_n)
		!(prim_pin.oe && alt_pin.oe))
		else $error("both locations pulled");

endmodule : dbgtp_event_line

/* test/dbgtp_conv.sv */
// Command converter model for one open-drain debug-event line
module dbgtp_conv
	import dbgtp_pkg::*;
(
	// Converter request, high pulls the line low
	input  wire logic pull,
	// Device drive
	input  wire logic dev_out,
	input  wire logic dev_oe,
	// Resolved line level
	output logic      level
);
	timeunit 1ns;
	timeprecision 1ps;

	// Pull-up wins only while nobody pulls low
	assign level = !(pull || (dev_oe && dev_out == PIN_LOW));
endmodule : dbgtp_conv

/* test/test_dbgtp_top.sv */
// Self-checking bench for the debug-event and trace pin block
module test_dbgtp_top
	import dbgtp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk = 1'h0;
	logic rst_n, sel;
	logic [3:0] pull;
	logic [1:0] entered;
	logic controller_debug_event_in, controller_debug_event_out;
	logic controller_debug_event_oe, controller_debug_event_alt_in;
	logic controller_debug_event_alt_out, controller_debug_event_alt_oe;
	logic sigproc_debug_event_in, sigproc_debug_event_out;
	logic sigproc_debug_event_oe, sigproc_debug_event_alt_in;
	logic sigproc_debug_event_alt_out, sigproc_debug_event_alt_oe;
	logic controller_debug_request, sigproc_debug_request;
	logic trace_mode_write;
	dbgtp_trace_s trace_source;
	logic [TRACE_PINS-1:0] trace_mode_value, trace_mode, gpio_out_value;
	logic [TRACE_PINS-1:0] gpio_out_enable, gpio_in_level, trace_pin_in;
	logic [TRACE_PINS-1:0] trace_pin_out, trace_pin_oe, eoe;
	logic [6:0] obs;
	int num_errors = 0;
	int check_count = 0;
	int seed = 67542;
	int cycles = 0;
	int cnt [7];

	dbgtp_top uut (.clk, .rst_n, .debug_pin_location_select(sel),
		.controller_debug_event_in, .controller_debug_event_out,
		.controller_debug_event_oe, .controller_debug_event_alt_in,
		.controller_debug_event_alt_out, .controller_debug_event_alt_oe,
		.sigproc_debug_event_in, .sigproc_debug_event_out,
		.sigproc_debug_event_oe, .sigproc_debug_event_alt_in,
		.sigproc_debug_event_alt_out, .sigproc_debug_event_alt_oe,
		.controller_debug_entered(entered[0]), .controller_debug_request,
		.sigproc_debug_entered(entered[1]), .sigproc_debug_request,
		.trace_source, .trace_mode_write, .trace_mode_value, .trace_mode,
		.gpio_out_value, .gpio_out_enable, .gpio_in_level,
		.trace_pin_in, .trace_pin_out, .trace_pin_oe);

	dbgtp_conv u_cp (.pull(pull[0]), .dev_out(controller_debug_event_out),
		.dev_oe(controller_debug_event_oe),
		.level(controller_debug_event_in));
	dbgtp_conv u_ca (.pull(pull[1]), .dev_out(controller_debug_event_alt_out),
		.dev_oe(controller_debug_event_alt_oe),
		.level(controller_debug_event_alt_in));
	dbgtp_conv u_sp (.pull(pull[2]), .dev_out(sigproc_debug_event_out),
		.dev_oe(sigproc_debug_event_oe),
		.level(sigproc_debug_event_in));
	dbgtp_conv u_sa (.pull(pull[3]), .dev_out(sigproc_debug_event_alt_out),
		.dev_oe(sigproc_debug_event_alt_oe),
		.level(sigproc_debug_event_alt_in));

	assign obs = {|{controller_debug_event_out, controller_debug_event_alt_out,
		sigproc_debug_event_out, sigproc_debug_event_alt_out},
		sigproc_debug_request, controller_debug_request,
		sigproc_debug_event_alt_oe, sigproc_debug_event_oe,
		controller_debug_event_alt_oe, controller_debug_event_oe};

	initial
	begin
		forever #4 clk = ~clk;
	end

	task end_of_test;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test

	// Run is about 700 cycles, ceiling leaves ample margin
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 8000)
		begin
			num_errors++;
			$display("unexpected at %0t: timeout", $time);
			end_of_test();
		end
	end

	task fail(string m);
		num_errors++;
		$display("unexpected at %0t: %s", $time, m);
	endtask : fail

	task cmp_n(int got, int exp, string m);
		check_count++;
		if (got != exp)
			fail(m);
	endtask : cmp_n

	task cmp_v(logic [5:0] got, logic [5:0] exp, string m);
		check_count++;
		if (got !== exp)
			fail(m);
	endtask : cmp_v

	function automatic logic [5:0] exp_out(logic [5:0] m, s, g);
		return (m & s) | (~m & g);
	endfunction : exp_out

	// Counts cycles each observed signal is high, sampled mid-cycle
	task window(int n);
		cnt = '{default: 0};
		repeat (n)
		begin
			@(negedge clk);
			if ($isunknown(obs))
				fail("unknown on event pins");
			for (int i = 0; i < 7; i++)
				if (obs[i] === 1'h1)
					cnt[i]++;
		end
	endtask : window

	// Pull one line, then enter debug and watch the acknowledge
	task ev_test(int l, int alt_on);
		int core;
		core = l / 2;
		@(posedge clk);
		pull[l] <= 1'h1;
		repeat (2 + ($random(seed) & 3)) @(posedge clk);
		pull[l] <= 1'h0;
		window(10);
		cmp_n(cnt[4 + core], (l % 2) == alt_on, "request count");
		@(posedge clk);
		entered[core] <= 1'h1;
		@(posedge clk);
		entered[core] <= 1'h0;
		window(10);
		for (int i = 0; i < 4; i++)
			cmp_n(cnt[i], (i == 2 * core + alt_on) ? 3 : 0, "ack");
		cmp_n(cnt[4 + core], 0, "own ack requested");
		cmp_n(cnt[6], 0, "line driven high");
		repeat (12) @(posedge clk);
		$display("test event line %0d select %0d done", l, alt_on);
	endtask : ev_test

	initial
	begin
		rst_n = 1'h0;
		sel = 1'h0;
		pull = 4'h0;
		entered = 2'h0;
		trace_source = '0;
		trace_mode_write = 1'h0;
		trace_mode_value = 6'h00;
		gpio_out_value = 6'h00;
		gpio_out_enable = 6'h00;
		trace_pin_in = 6'h3F;
		repeat (20) @(posedge clk);
		cmp_v(trace_mode, 6'h00, "reset mode");
		cmp_v(trace_pin_oe, 6'h00, "reset pin drive");
		cmp_v(6'(obs), 6'h00, "reset event drive");
		rst_n <= 1'h1;
		repeat (8) @(posedge clk);
		cmp_v(trace_pin_oe, 6'h00, "trace pins not inputs");
		for (int a = 0; a < 2; a++)
		begin
			sel <= 1'(a);
			repeat (10) @(posedge clk);
			for (int l = 0; l < 4; l++)
				ev_test(l, a);
		end
		for (int i = 0; i < 40; i++)
		begin
			@(posedge clk);
			trace_mode_write <= 1'h1;
			trace_mode_value <= (i == 0) ? 6'h3F : (i == 1) ? 6'h00
				: 6'($random(seed));
			trace_source <= dbgtp_trace_s'(6'($random(seed)));
			gpio_out_value <= 6'($random(seed));
			gpio_out_enable <= 6'($random(seed));
			trace_pin_in <= 6'($random(seed));
			@(posedge clk);
			trace_mode_write <= 1'h0;
			repeat (5) @(posedge clk);
			@(negedge clk);
			eoe = trace_mode_value | gpio_out_enable;
			cmp_v(trace_mode, trace_mode_value, "mode");
			cmp_v(trace_pin_oe, eoe, "pin drive");
			cmp_v(trace_pin_out & eoe, exp_out(trace_mode_value,
				trace_source, gpio_out_value) & eoe, "pin value");
			cmp_v(gpio_in_level, trace_pin_in, "input level");
		end
		$display("test trace pins done");
		@(posedge clk);
		rst_n <= 1'h0;
		repeat (4) @(posedge clk);
		@(negedge clk);
		cmp_v(trace_mode, 6'h00, "mode after reset");
		cmp_v(trace_pin_oe, 6'h00, "drive after reset");
		@(posedge clk);
		rst_n <= 1'h1;
		repeat (8) @(posedge clk);
		@(negedge clk);
		cmp_v(trace_pin_oe, gpio_out_enable, "gpio drive after reset");
		cmp_v(trace_pin_out & gpio_out_enable,
			gpio_out_value & gpio_out_enable, "gpio value");
		cmp_v(6'(obs), 6'h00, "events after reset");
		$display("test mid-run reset done");
		end_of_test();
	end
endmodule : test_dbgtp_top
